// >>> design/asc_pkg.sv
// Package with register map, field positions, states and timing for the sample/convert control
package asc_pkg;
  // Register offsets (word index on the plain register port)
  localparam logic [3:0] ASC_CTRL_OFS = 4'h0;
  localparam logic [3:0] ASC_INSEL_OFS = 4'h1;
  localparam logic [3:0] ASC_IRQ_STAT_OFS = 4'h2;
  localparam logic [3:0] ASC_IRQ_MASK_OFS = 4'h3;
  localparam logic [3:0] ASC_STATUS_OFS = 4'h4;
  // Control register field positions
  localparam int ASC_DONE_BIT = 0;
  localparam int ASC_SAMPLE_ACTIVE_BIT = 1;
  localparam int ASC_AUTO_SAMPLE_START_BIT = 2;
  localparam int ASC_SIM_BIT = 3;
  localparam int ASC_TRIG_LSB = 5;
  localparam int ASC_CHCNT_LSB = 8;
  localparam int ASC_12B_BIT = 10;
  localparam int ASC_ON_BIT = 15;
  // Input select field positions
  localparam int ASC_POSA_LSB = 0;
  localparam int ASC_NEGA_BIT = 7;
  localparam int ASC_POSB_LSB = 8;
  localparam int ASC_NEGB_BIT = 15;
  // Writable masks, unimplemented bits read zero
  localparam logic [15:0] ASC_CTRL_WMASK = 16'h87EF;
  localparam logic [15:0] ASC_INSEL_WMASK = 16'h9F9F;
  localparam logic [15:0] ASC_CTRL_RST = 16'h0000;
  localparam logic [15:0] ASC_INSEL_RST = 16'h0000;
  // Trigger select codes
  localparam logic [2:0] ASC_TRIG_SW = 3'h0;
  localparam logic [2:0] ASC_TRIG_PIN = 3'h1;
  localparam logic [2:0] ASC_TRIG_TMR_A = 3'h2;
  localparam logic [2:0] ASC_TRIG_TMR_B = 3'h4;
  localparam logic [2:0] ASC_TRIG_AUTO = 3'h7;
  // Interrupt status bits
  localparam int ASC_IRQ_DONE = 0;
  localparam int ASC_IRQ_CONV_START = 1;
  localparam int ASC_IRQ_W = 2;
  // Timing: auto sample time and conversion time
  localparam int ASC_CLK_MHZ = 200;
  localparam int ASC_AUTO_SAMPLE_ACTIVE_NS = 100;
  localparam int ASC_CONV_NS = 200;
  localparam int ASC_AUTO_SAMPLE_ACTIVE_CYC = (ASC_AUTO_SAMPLE_ACTIVE_NS * ASC_CLK_MHZ + 999) / 1000;
  localparam int ASC_CONV_CYC = (ASC_CONV_NS * ASC_CLK_MHZ + 999) / 1000;
  localparam int ASC_CNT_W = 8;
  localparam int ASC_NCH = 4;
  // Sequencer states, Gray along idle-sample-convert-done
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_SAMPLE = 2'b01,
    ASC_CONVERT = 2'b11,
    ASC_FINISH = 2'b10
  } asc_state_t;
endpackage : asc_pkg

// >>> design/asc_if.sv
// Interface carrying the channel sample strobes between sequencer and strobe generator
`timescale 1ns/100ps
interface asc_if;
  logic [1:0] chan_count;
  logic sim_en;
  logic start;
  logic [3:0] strobe;
  logic busy;
  modport seq (output chan_count, output sim_en, output start, input strobe, input busy);
  modport gen (input chan_count, input sim_en, input start, output strobe, output busy);
endinterface : asc_if

// >>> design/asc_hold_strobe.sv
// Hold strobe generator: simultaneous or sequential hold of sample-and-hold channels
`timescale 1ns/100ps
module asc_hold_strobe
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  asc_if.gen bus
);
  logic [3:0] enabled;
  logic [3:0] strobe_d;
  logic [3:0] strobe_q;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic busy_q;
  logic busy_d;

  // Channels enabled by channel count: 1, 2 or 4
  assign enabled = bus.chan_count[1] ? 4'hF : (bus.chan_count[0] ? 4'h3 : 4'h1);

  // Simultaneous pulses all enabled; sequential walks one per cycle
  always_comb begin
    strobe_d = 4'h0;
    idx_d = idx_q;
    busy_d = busy_q;
    if (bus.start && bus.sim_en) begin
      strobe_d = enabled; // R3
    end else if (bus.start) begin
      strobe_d = 4'h1; // R4
      idx_d = 2'h0;
      busy_d = (enabled != 4'h1);
    end else if (busy_q) begin
      idx_d = idx_q + 2'h1;
      strobe_d = 4'h1 << (idx_q + 2'h1); // R4
      busy_d = !((idx_q + 2'h1 == 2'h3) || !enabled[idx_q + 2'h2]);
    end
  end

  // Short state registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_q <= 4'h0;
      idx_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      strobe_q <= strobe_d;
      idx_q <= idx_d;
      busy_q <= busy_d;
    end
  end

  assign bus.strobe = strobe_q;
  // Registered only: start depends on busy, so a start term would close a loop
  assign bus.busy = busy_q;
endmodule : asc_hold_strobe

// >>> design/asc_ctrl.sv
// Top of the sample/convert control: registers, sequencer, interrupt
//
// Functional notes
// R1: Simultaneous select only for channel count 01/1x
// R2: Twelve-bit mode: simultaneous bit reads zero
// R3: Simultaneous: hold channels 0-3 or 0-1 together
// R4: Sequential: hold enabled channels one by one
// R5: Auto start resamples after conversion, sets active
// R6: Manual mode waits for sample-active set
// R7: Software writes one to start sampling
// R8: Trigger 000: software clear starts conversion
// R9: Other trigger clears sample-active itself
// R10: Conversion end sets complete flag
// R11: Complete flag clears by zero, never set
// R12: Clearing complete flag leaves operation alone
// R13: New conversion start clears complete flag
// R14: Five-bit positive selects pick input N
// R15: Twelve-bit mode uses one channel only
// R16: Trigger 111 internal counter ends sampling
// R17: Negative select follows active sample A/B
// R18: Unimplemented bits read zero, writes ignored
`timescale 1ns/100ps
module asc_ctrl
  import asc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic TRIG_PIN_I,
  input wire logic TRIG_TMR_A_I,
  input wire logic TRIG_TMR_B_I,
  input wire logic ALT_AB_I,
  output logic [4:0] POS_SEL_O,
  output logic NEG_SEL_O,
  output logic SAMPLING_O,
  output logic [3:0] HOLD_STROBE_O,
  output logic CONV_START_O,
  output logic IRQ_O
);
  logic rst_s1_q;
  logic rst_n;
  logic [15:0] ctrl_q;
  logic [15:0] insel_q;
  logic [ASC_IRQ_W-1:0] irq_stat_q;
  logic [ASC_IRQ_W-1:0] irq_mask_q;
  logic [15:0] rdata_q;
  asc_state_t state_q;
  asc_state_t state_d;
  logic [ASC_CNT_W-1:0] cnt_q;
  logic [ASC_CNT_W-1:0] cnt_d;
  logic trig_pin_q;
  logic sample_active_q;
  logic done_q;
  logic side_b_q;
  logic [4:0] pos_q;
  logic neg_q;
  logic conv_start_q;
  logic irq_q;
  asc_if hold_bus ();

  // Reset release through two flops
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Address decode and field views
  logic wr_ctrl;
  logic wr_insel;
  logic wr_stat;
  logic wr_mask;
  logic mode_12b;
  logic [1:0] chan_cnt;
  logic sim_sel;
  logic sim_eff;
  logic auto_start;
  logic [2:0] trig_sel;
  logic module_on;
  assign wr_ctrl = WR_I && (ADDR_I == ASC_CTRL_OFS);
  assign wr_insel = WR_I && (ADDR_I == ASC_INSEL_OFS);
  assign wr_stat = WR_I && (ADDR_I == ASC_IRQ_STAT_OFS);
  assign wr_mask = WR_I && (ADDR_I == ASC_IRQ_MASK_OFS);
  assign mode_12b = ctrl_q[ASC_12B_BIT];
  // Twelve-bit mode forces one channel
  assign chan_cnt = mode_12b ? 2'b00 : ctrl_q[ASC_CHCNT_LSB +: 2]; // R15
  assign sim_sel = ctrl_q[ASC_SIM_BIT] && !mode_12b; // R2
  assign sim_eff = sim_sel && (chan_cnt != 2'b00); // R1
  assign auto_start = ctrl_q[ASC_AUTO_SAMPLE_START_BIT];
  assign trig_sel = ctrl_q[ASC_TRIG_LSB +: 3];
  assign module_on = ctrl_q[ASC_ON_BIT];

  // Trigger selection; pin takes its rising edge
  logic pin_rise;
  logic hw_trig;
  logic cnt_expired;
  assign pin_rise = TRIG_PIN_I && !trig_pin_q;
  assign cnt_expired = (cnt_q == ASC_CNT_W'(ASC_AUTO_SAMPLE_ACTIVE_CYC - 1));
  assign hw_trig = (trig_sel == ASC_TRIG_PIN) ? pin_rise :
                   (trig_sel == ASC_TRIG_TMR_A) ? TRIG_TMR_A_I :
                   (trig_sel == ASC_TRIG_TMR_B) ? TRIG_TMR_B_I :
                   (trig_sel == ASC_TRIG_AUTO) ? cnt_expired : 1'b0; // R16

  // Software write of sample-active and complete flag
  logic sw_sample_active_set;
  logic sw_sample_active_clr;
  logic sw_done_clr;
  assign sw_sample_active_set = wr_ctrl && WDATA_I[ASC_SAMPLE_ACTIVE_BIT] && !sample_active_q; // R7
  assign sw_sample_active_clr = wr_ctrl && !WDATA_I[ASC_SAMPLE_ACTIVE_BIT] && sample_active_q;
  assign sw_done_clr = wr_ctrl && !WDATA_I[ASC_DONE_BIT]; // R11

  // Sequencer events
  logic begin_sample;
  logic end_sample;
  logic conv_end;
  assign begin_sample = module_on && (state_q == ASC_IDLE) &&
                        (auto_start || sw_sample_active_set); // R6
  assign end_sample = (state_q == ASC_SAMPLE) && !hold_bus.busy &&
                      ((trig_sel == ASC_TRIG_SW) ? sw_sample_active_clr : hw_trig); // R8 R9
  assign conv_end = (state_q == ASC_CONVERT) &&
                    (cnt_q == ASC_CNT_W'(ASC_CONV_CYC - 1));

  // Next state and phase counter
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + ASC_CNT_W'(1);
    case (state_q)
      ASC_IDLE: begin
        cnt_d = '0;
        if (begin_sample) begin
          state_d = ASC_SAMPLE;
        end
      end
      ASC_SAMPLE: begin
        if (end_sample) begin
          state_d = ASC_CONVERT;
          cnt_d = '0;
        end else if (cnt_expired) begin
          cnt_d = cnt_q;
        end
      end
      ASC_CONVERT: begin
        if (conv_end) begin
          state_d = ASC_FINISH;
        end
      end
      ASC_FINISH: begin
        state_d = ASC_IDLE;
        cnt_d = '0;
      end
      default: begin
        state_d = ASC_IDLE;
        cnt_d = '0;
      end
    endcase
    if (!module_on) begin
      state_d = ASC_IDLE;
      cnt_d = '0;
    end
  end

  // Sequencer registers; auto restart happens from idle next cycle
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ASC_IDLE;
      cnt_q <= '0;
      trig_pin_q <= 1'b0;
    end else begin
      state_q <= state_d; // R5
      cnt_q <= cnt_d;
      trig_pin_q <= TRIG_PIN_I;
    end
  end

  // Sample-active bit follows the sequencer, set at sampling start, cleared at sampling end or module off
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sample_active_q <= 1'b0;
    end else if (begin_sample) begin
      sample_active_q <= 1'b1; // R5
    end else if (end_sample || !module_on) begin
      sample_active_q <= 1'b0; // R9
    end
  end

  // Complete flag: hardware set beats software clear, start clears it
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (conv_end) begin
      done_q <= 1'b1; // R10
    end else if (end_sample) begin
      done_q <= 1'b0; // R13
    end else if (sw_done_clr) begin
      done_q <= 1'b0; // R12
    end
  end

  // Control and input select storage, unimplemented bits dropped
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= ASC_CTRL_RST;
      insel_q <= ASC_INSEL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= WDATA_I & ASC_CTRL_WMASK & 16'hFFFC; // R18
      end
      if (wr_insel) begin
        insel_q <= WDATA_I & ASC_INSEL_WMASK; // R18
      end
    end
  end

  // Interrupt status: set wins over write-one clear
  logic [ASC_IRQ_W-1:0] irq_events;
  assign irq_events = {end_sample, conv_end};
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? WDATA_I[ASC_IRQ_W-1:0] : '0)) | irq_events;
      if (wr_mask) begin
        irq_mask_q <= WDATA_I[ASC_IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read mux; unmapped reads give zero
  logic [15:0] ctrl_view;
  logic [15:0] rd_mux;
  assign ctrl_view = {ctrl_q[15:4], sim_sel, ctrl_q[2], sample_active_q, done_q}; // R2
  assign rd_mux = (ADDR_I == ASC_CTRL_OFS) ? ctrl_view :
                  (ADDR_I == ASC_INSEL_OFS) ? insel_q :
                  (ADDR_I == ASC_IRQ_STAT_OFS) ? {14'h0000, irq_stat_q} :
                  (ADDR_I == ASC_IRQ_MASK_OFS) ? {14'h0000, irq_mask_q} :
                  (ADDR_I == ASC_STATUS_OFS) ? {14'h0000, state_q} : 16'h0000;
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= RD_I ? rd_mux : 16'h0000;
    end
  end

  // Active sample A/B latched at sampling start so routing stays stable
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      side_b_q <= 1'b0;
      pos_q <= 5'h00;
      neg_q <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      if (begin_sample) begin
        side_b_q <= ALT_AB_I;
      end
      pos_q <= side_b_q ? insel_q[ASC_POSB_LSB +: 5] : insel_q[ASC_POSA_LSB +: 5]; // R14
      neg_q <= side_b_q ? insel_q[ASC_NEGB_BIT] : insel_q[ASC_NEGA_BIT]; // R17
      conv_start_q <= end_sample;
    end
  end

  // Hold strobes fire when sampling ends
  assign hold_bus.chan_count = chan_cnt;
  assign hold_bus.sim_en = sim_eff;
  assign hold_bus.start = (state_d == ASC_CONVERT) && (state_q == ASC_SAMPLE);

  asc_hold_strobe u_hold (
    .clk_i(SYS_CLK_I),
    .rst_n_i(rst_n),
    .bus(hold_bus)
  );

  assign RDATA_O = rdata_q;
  assign POS_SEL_O = pos_q;
  assign NEG_SEL_O = neg_q;
  assign SAMPLING_O = sample_active_q;
  assign HOLD_STROBE_O = hold_bus.strobe;
  assign CONV_START_O = conv_start_q;
  assign IRQ_O = irq_q;
endmodule : asc_ctrl

// >>> testbench/asc_ctrl_monitor.sv
// Port-level checker for the sample/convert control
`timescale 1ns/100ps
module asc_ctrl_monitor
  import asc_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic ALT_AB_I,
  input wire logic [4:0] POS_SEL_O,
  input wire logic NEG_SEL_O,
  input wire logic SAMPLING_O,
  input wire logic CONV_START_O
);
  logic [15:0] insel_q;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Shadow of the input select, so routing can be predicted
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      insel_q <= 16'h0000;
    else if (WR_I && ADDR_I == ASC_INSEL_OFS)
      insel_q <= WDATA_I;
  end

  conv_one_pulse_a: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("conversion start pulse too long");
  conv_on_end_a: assert property ($fell(SAMPLING_O) |-> ##[0:1] CONV_START_O)
    else $error("sampling ended without conversion start");
  hold_in_conv_a: assert property (CONV_START_O |-> !SAMPLING_O [*8])
    else $error("sampling resumed during conversion");
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data outside read cycle");
  ctrl_resv_a: assert property (RD_I && ADDR_I == ASC_CTRL_OFS |=>
    (RDATA_O & ~ASC_CTRL_WMASK) == 16'h0000) else $error("reserved control bit set");
  twelve_sim_a: assert property (RD_I && ADDR_I == ASC_CTRL_OFS |=>
    !(RDATA_O[ASC_12B_BIT] && RDATA_O[ASC_SIM_BIT])) else $error("simultaneous bit in 12b");
  unmapped_zero_a: assert property (RD_I && ADDR_I > ASC_STATUS_OFS |=>
    RDATA_O == 16'h0000) else $error("unmapped read not zero");
  input_route_a: assert property ($rose(SAMPLING_O) && $stable(ALT_AB_I)
    ##1 $stable(ALT_AB_I) |->
    POS_SEL_O == (ALT_AB_I ? insel_q[12:8] : insel_q[4:0]) &&
    NEG_SEL_O == (ALT_AB_I ? insel_q[15] : insel_q[7])) else $error("input routing wrong");
endmodule : asc_ctrl_monitor

bind asc_ctrl asc_ctrl_monitor u_mon (.SYS_CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I,
  .RD_I, .RDATA_O, .ALT_AB_I, .POS_SEL_O, .NEG_SEL_O, .SAMPLING_O, .CONV_START_O);

// >>> testbench/asc_analog_model.sv
// Trigger sources and sample-and-hold bank beside the control
`timescale 1ns/100ps
module asc_analog_model
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic [2:0] code_i,
  input wire logic clr_i,
  input wire logic [3:0] strobe_i,
  output logic pin_o,
  output logic tmr_a_o,
  output logic tmr_b_o,
  output logic [3:0] held_o,
  output logic [2:0] nheld_o
);
  initial {pin_o, tmr_a_o, tmr_b_o, held_o, nheld_o} = 10'h000;
  // One-cycle trigger events; hold bank records which channels froze
  always @(posedge clk_i) begin
    pin_o <= fire_i && code_i == ASC_TRIG_PIN;
    tmr_a_o <= fire_i && code_i == ASC_TRIG_TMR_A;
    tmr_b_o <= fire_i && code_i == ASC_TRIG_TMR_B;
    held_o <= clr_i ? 4'h0 : held_o | strobe_i;
    nheld_o <= clr_i ? 3'h0 : nheld_o + {2'b00, |strobe_i};
  end
endmodule : asc_analog_model

// >>> testbench/tb_top.sv
// Self-checking bench for the sample/convert control
`timescale 1ns/100ps
module tb_top;
  import asc_pkg::*;
  logic clk, rst_n, wr, rd, alt, fire, clr, rd_q;
  logic pin, tmr_a, tmr_b, neg, sample_active, conv, irq;
  logic [3:0] addr, hold, held;
  logic [15:0] wdata, rdata;
  logic [15:0] exp_q[$];
  logic [2:0] code, nheld;
  logic [4:0] pos;
  int mismatches, total_checks, seed;

  asc_ctrl u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TRIG_PIN_I(pin), .TRIG_TMR_A_I(tmr_a),
    .TRIG_TMR_B_I(tmr_b), .ALT_AB_I(alt), .POS_SEL_O(pos), .NEG_SEL_O(neg),
    .SAMPLING_O(sample_active), .HOLD_STROBE_O(hold), .CONV_START_O(conv), .IRQ_O(irq));
  asc_analog_model u_far (.clk_i(clk), .fire_i(fire), .code_i(code), .clr_i(clr),
    .strobe_i(hold), .pin_o(pin), .tmr_a_o(tmr_a), .tmr_b_o(tmr_b), .held_o(held),
    .nheld_o(nheld));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Expected read data is noted for the watcher below
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) if (rd_q === 1'b1) chk(rdata, exp_q.pop_front());

  // Bounded wait; a missing conversion start ends the run
  task automatic wait_conv();
    int n;
    for (n = 0; n < 300 && conv !== 1'b1; n++) @(negedge clk);
    chk({15'h0000, conv}, 16'h0001);
    if (n == 300) report_and_stop();
  endtask : wait_conv

  // Software-timed run; done flag and frozen channels checked
  task automatic run_sw(input logic [15:0] c, input logic [3:0] eh, input logic [2:0] en);
    logic [15:0] d, e;
    d = 16'($random(seed));
    e = {c[15:4], c[3] & ~c[10], c[2:0]};
    alt <= d[6];
    clr <= 1'b1;
    wr_reg(ASC_INSEL_OFS, d);
    clr <= 1'b0;
    rd_reg(ASC_INSEL_OFS, d & ASC_INSEL_WMASK);
    // Module must be on before the sample-active write is honoured
    wr_reg(ASC_CTRL_OFS, c | 16'h8000);
    wr_reg(ASC_CTRL_OFS, c | 16'h8002);
    wr_reg(ASC_CTRL_OFS, c | 16'h8000);
    wait_conv();
    rd_reg(ASC_CTRL_OFS, e | 16'h8000);
    wr_reg(ASC_CTRL_OFS, c | 16'h8000);
    repeat (45) @(posedge clk);
    rd_reg(ASC_CTRL_OFS, e | 16'h8001);
    chk({12'h000, held}, {12'h000, eh});
    chk({13'h0000, nheld}, {13'h0000, en});
  endtask : run_sw

  // Hardware-ended sampling for one trigger source
  task automatic run_trig(input logic [2:0] t);
    wr_reg(ASC_CTRL_OFS, 16'h8002 | {8'h00, t, 5'h00});
    @(posedge clk);
    code <= t;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_conv();
    chk({15'h0000, sample_active}, 16'h0000);
    repeat (45) @(posedge clk);
  endtask : run_trig

  initial begin
    {wr, rd, alt, fire, clr, rst_n} = 6'h00;
    addr = 4'h0;
    wdata = 16'h0000;
    code = 3'h0;
    seed = 32'h52ee;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 6; a++) rd_reg(a == 5 ? 4'hF : 4'(a), 16'h0000);
    wr_reg(ASC_CTRL_OFS, 16'h7810);
    rd_reg(ASC_CTRL_OFS, 16'h0000);
    wr_reg(ASC_CTRL_OFS, 16'h0408);
    rd_reg(ASC_CTRL_OFS, 16'h0400);
    run_sw(16'h0000, 4'h1, 3'h1);
    chk({15'h0000, irq}, 16'h0000);
    rd_reg(ASC_IRQ_STAT_OFS, 16'h0003);
    wr_reg(ASC_IRQ_MASK_OFS, 16'h0001);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(ASC_IRQ_STAT_OFS, 16'h0003);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    run_sw(16'h0008, 4'h1, 3'h1);
    run_sw(16'h0108, 4'h3, 3'h1);
    run_sw(16'h0208, 4'hF, 3'h1);
    run_sw(16'h0100, 4'h3, 3'h2);
    run_sw(16'h0200, 4'hF, 3'h4);
    run_sw(16'h0608, 4'h1, 3'h1);
    wr_reg(ASC_CTRL_OFS, 16'h8001);
    rd_reg(ASC_CTRL_OFS, 16'h8001);
    wr_reg(ASC_CTRL_OFS, 16'h8000);
    wr_reg(ASC_CTRL_OFS, 16'h8001);
    rd_reg(ASC_CTRL_OFS, 16'h8000);
    for (int k = 0; k < 4; k++) run_trig(k == 3 ? 3'h7 : 3'(1 << k));
    wr_reg(ASC_CTRL_OFS, 16'h80E6);
    wait_conv();
    repeat (2) @(posedge clk);
    wait_conv();
    wr_reg(ASC_CTRL_OFS, 16'h8000);
    repeat (80) @(posedge clk);
    chk({15'h0000, sample_active}, 16'h0000);
    report_and_stop();
  end
endmodule : tb_top
